// file: core/vcom_pkg.sv
package vcom_pkg;
    // =========================================================================
    // timing
    // =========================================================================
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned DEFAULT_BAUD  = 115200;
    localparam int unsigned BIT_CYCLES    = CLK_HZ / DEFAULT_BAUD;
    localparam int unsigned DATA_BITS     = 8;
    localparam int unsigned FRAME_BITS    = DATA_BITS + 2;
    localparam int unsigned FIFO_DEPTH    = 4;
    localparam int unsigned FIFO_WIDTH    = 8;

    // =========================================================================
    // handshake modes
    // =========================================================================
    typedef enum logic [1:0] {
        HS_DISABLED = 2'b00,
        HS_RTS      = 2'b01,
        HS_CTS      = 2'b10,
        HS_RTSCTS   = 2'b11
    } hs_mode_e;

    localparam hs_mode_e HS_RESET = HS_DISABLED;

    // transmitter states, gray along idle-start-data-stop
    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_START = 2'b01,
        TX_DATA  = 2'b11,
        TX_STOP  = 2'b10
    } tx_state_e;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } byte_s;
endpackage

// file: core/byte_fifo.sv
`timescale 1ns/100ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             mclk,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];

    function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
        inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wp_r <= inc(wp_r);
            if (pop)  rp_r <= inc(rp_r);
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge mclk) begin
        if (push) mem_r[wp_r] <= in_data;
    end
endmodule // byte_fifo

// file: core/vcom_flow.sv
`timescale 1ns/100ps
// Notes on behaviour
// - in rts and rtscts modes clear-to-send drops whenever the receive buffer from the target is full.
// - no new character starts while request-to-send is low in honouring modes.
// - a character already shifting out always finishes; never aborted.
// - disabled mode: clear-to-send undriven, request-to-send ignored.
// - rts mode: clear-to-send driven from buffer full, request-to-send ignored.
// - cts and rtscts gate transmit on request-to-send; cts leaves clear-to-send undriven.
// - rtscts drives clear-to-send from buffer full and gates transmit too.
// - default link 115200 baud, 8N1, handshake disabled.
// - new characters start in either direction only while port enable is asserted; one already under way finishes.
module vcom_flow
    import vcom_pkg::*;
#(
    parameter int BIT_CYC = BIT_CYCLES,
    parameter int DEPTH   = FIFO_DEPTH
) (
    input  wire logic             mclk,
    input  wire logic             reset_n,
    input  wire vcom_pkg::hs_mode_e mode_cfg,
    input  wire logic             port_enable,
    input  wire logic             target_tx_i,
    input  wire logic             target_rts_i,
    output logic                  target_rx_o,
    output logic                  target_cts_o,
    output logic                  target_cts_oe_n,
    input  wire logic             host_tx_valid,
    output logic                  host_tx_ready,
    input  wire logic [7:0]       host_tx_data,
    output logic                  host_rx_valid,
    input  wire logic             host_rx_ready,
    output logic [7:0]            host_rx_data
);
    import vcom_pkg::*;

    localparam int CW = $clog2(BIT_CYC + 1);

    // =========================================================================
    // input synchronisers and mode sampling
    // =========================================================================
    logic [2:0] rx_sy_r;
    logic [2:0] rts_sy_r;
    logic       rx_lvl_r;
    logic       rts_lvl_r;
    hs_mode_e   mode_r;
    logic       live_r;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rx_sy_r   <= 3'b111;
            rts_sy_r  <= 3'b000;
            rx_lvl_r  <= 1'b1;
            rts_lvl_r <= 1'b0;
            mode_r    <= HS_RESET;
            live_r    <= 1'b0;
        end else begin
            rx_sy_r   <= {rx_sy_r[1:0], target_tx_i};
            rts_sy_r  <= {rts_sy_r[1:0], target_rts_i};
            if (rx_sy_r[1] == rx_sy_r[2])   rx_lvl_r  <= rx_sy_r[2];
            if (rts_sy_r[1] == rts_sy_r[2]) rts_lvl_r <= rts_sy_r[2];
            mode_r    <= mode_cfg;
            live_r    <= 1'b1;
        end
    end

    wire honour_rts = (mode_r == HS_CTS) || (mode_r == HS_RTSCTS);
    wire drive_cts  = (mode_r == HS_RTS) || (mode_r == HS_RTSCTS);
    wire rts_ok     = !honour_rts || rts_lvl_r;

    // =========================================================================
    // receiver from target into buffer
    // =========================================================================
    logic          rx_busy_r;
    logic [CW-1:0] rx_cnt_r;
    logic [3:0]    rx_bit_r;
    logic [7:0]    rx_sh_r;
    logic          rx_push_r;
    logic          fifo_in_ready;

    wire rx_tick = rx_busy_r && (rx_cnt_r == '0);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rx_busy_r <= 1'b0;
            rx_cnt_r  <= '0;
            rx_bit_r  <= '0;
            rx_sh_r   <= '0;
            rx_push_r <= 1'b0;
        end else begin
            rx_push_r <= 1'b0;
            if (!rx_busy_r) begin
                if (port_enable && !rx_lvl_r) begin
                    rx_busy_r <= 1'b1;
                    rx_cnt_r  <= CW'(BIT_CYC / 2);
                    rx_bit_r  <= '0;
                end
            end else if (rx_tick) begin
                rx_cnt_r <= CW'(BIT_CYC - 1);
                rx_bit_r <= rx_bit_r + 4'h1;
                if (rx_bit_r == 4'h0 && rx_lvl_r) begin
                    rx_busy_r <= 1'b0;
                end else if (rx_bit_r == 4'(FRAME_BITS - 1)) begin
                    rx_busy_r <= 1'b0;
                    rx_push_r <= rx_lvl_r;
                end else if (rx_bit_r != 4'h0) begin
                    rx_sh_r <= {rx_lvl_r, rx_sh_r[7:1]};
                end
            end else begin
                rx_cnt_r <= rx_cnt_r - 1'b1;
            end
        end
    end

    byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) u_rx_fifo (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .in_valid  (rx_push_r),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_sh_r),
        .out_valid (host_rx_valid),
        .out_ready (host_rx_ready),
        .out_data  (host_rx_data)
    );

    // =========================================================================
    // clear-to-send pin
    // =========================================================================
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            target_cts_o    <= 1'b0;
            target_cts_oe_n <= 1'b1;
        end else begin
            target_cts_o    <= fifo_in_ready;
            target_cts_oe_n <= !drive_cts;
        end
    end

    // =========================================================================
    // transmitter toward target
    // =========================================================================
    tx_state_e     tx_st_r;
    logic [CW-1:0] tx_cnt_r;
    logic [2:0]    tx_bit_r;
    logic [7:0]    tx_sh_r;

    wire tx_go   = port_enable && rts_ok;
    wire tx_done = (tx_cnt_r == '0);
    // no byte taken in reset or on the release edge
    assign host_tx_ready = live_r && (tx_st_r == TX_IDLE) && tx_go;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tx_st_r     <= TX_IDLE;
            tx_cnt_r    <= '0;
            tx_bit_r    <= '0;
            tx_sh_r     <= '0;
            target_rx_o <= 1'b1;
        end else begin
            tx_cnt_r <= tx_done ? CW'(BIT_CYC - 1) : tx_cnt_r - 1'b1;
            case (tx_st_r)
                TX_IDLE: begin
                    target_rx_o <= 1'b1;
                    tx_cnt_r    <= CW'(BIT_CYC - 1);
                    if (host_tx_valid && host_tx_ready) begin
                        tx_sh_r     <= host_tx_data;
                        target_rx_o <= 1'b0;
                        tx_st_r     <= TX_START;
                    end
                end
                TX_START: if (tx_done) begin
                    target_rx_o <= tx_sh_r[0];
                    tx_sh_r     <= {1'b1, tx_sh_r[7:1]};
                    tx_bit_r    <= '0;
                    tx_st_r     <= TX_DATA;
                end
                TX_DATA: if (tx_done) begin
                    target_rx_o <= tx_sh_r[0];
                    tx_sh_r     <= {1'b1, tx_sh_r[7:1]};
                    tx_bit_r    <= tx_bit_r + 3'h1;
                    if (tx_bit_r == 3'(DATA_BITS - 1)) tx_st_r <= TX_STOP;
                end
                TX_STOP: if (tx_done) begin
                    tx_st_r <= TX_IDLE;
                end
                default: tx_st_r <= TX_IDLE;
            endcase
        end
    end

    // =========================================================================
    // checks
    // =========================================================================
    property p_cts_full;
        @(posedge mclk) disable iff (!reset_n)
        !fifo_in_ready |=> !target_cts_o;
    endproperty
    a_cts_full: assert property (p_cts_full) else $error("cts not dropped");

    property p_rts_gate;
        @(posedge mclk) disable iff (!reset_n)
        (tx_st_r == TX_IDLE && honour_rts && !rts_lvl_r) |=> tx_st_r == TX_IDLE;
    endproperty
    a_rts_gate: assert property (p_rts_gate) else $error("tx started under rts low");

    property p_no_abort;
        @(posedge mclk) disable iff (!reset_n)
        (tx_st_r == TX_START) |=> (tx_st_r == TX_START) || (tx_st_r == TX_DATA);
    endproperty
    a_no_abort: assert property (p_no_abort) else $error("frame aborted");

    property p_undriven;
        @(posedge mclk) disable iff (!reset_n)
        (mode_r == HS_DISABLED || mode_r == HS_CTS) |=> target_cts_oe_n;
    endproperty
    a_undriven: assert property (p_undriven) else $error("cts driven");

    property p_driven;
        @(posedge mclk) disable iff (!reset_n)
        (mode_r == HS_RTS || mode_r == HS_RTSCTS) |=> !target_cts_oe_n;
    endproperty
    a_driven: assert property (p_driven) else $error("cts not driven");

    property p_ignore;
        @(posedge mclk) disable iff (!reset_n)
        (mode_r == HS_RTS && port_enable && live_r && tx_st_r == TX_IDLE) |-> host_tx_ready;
    endproperty
    a_ignore: assert property (p_ignore) else $error("rts not ignored");

    property p_rtscts;
        @(posedge mclk) disable iff (!reset_n)
        (mode_r == HS_RTSCTS && !rts_lvl_r) |-> !host_tx_ready;
    endproperty
    a_rtscts: assert property (p_rtscts) else $error("rtscts tx not gated");

    property p_enable;
        @(posedge mclk) disable iff (!reset_n)
        !port_enable |-> !host_tx_ready;
    endproperty
    a_enable: assert property (p_enable) else $error("tx while disabled");

    property p_mode;
        @(posedge mclk) disable iff (!reset_n)
        reset_n |=> mode_r == $past(mode_cfg);
    endproperty
    a_mode: assert property (p_mode) else $error("mode not sampled");

    c_tx_frame: cover property (@(posedge mclk) tx_st_r == TX_STOP ##1 tx_st_r == TX_IDLE);
    c_rx_push:  cover property (@(posedge mclk) rx_push_r);
    c_full:     cover property (@(posedge mclk) !fifo_in_ready && drive_cts);
    c_rts_hold: cover property (@(posedge mclk) honour_rts && !rts_lvl_r && host_tx_valid);
endmodule // vcom_flow

// file: tb/target_uart.sv
`timescale 1ns/100ps
// =========================================================
// far-side uart model with rts/cts handshake
module target_uart #(
    parameter int BIT_CYC = 8
) (
    input  wire logic mclk,
    input  wire logic rx_line,
    input  wire logic cts_pin,
    output logic      tx_line,
    output logic      rts_out
);
    logic [7:0] rx_q[$];
    logic [7:0] sh;

    initial begin
        tx_line = 1'b1;
        rts_out = 1'b1;
    end

    // receiver keeps taking bytes after rts drops
    always begin
        @(negedge rx_line);
        repeat (BIT_CYC / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge mclk);
            sh[i] = rx_line;
        end
        repeat (BIT_CYC) @(posedge mclk);
        if (rx_line === 1'b1) rx_q.push_back(sh);
    end

    task automatic send(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        @(posedge mclk);
        while (cts_pin !== 1'b1) @(posedge mclk);
        for (int i = 0; i < 10; i++) begin
            tx_line <= fr[i];
            repeat (BIT_CYC) @(posedge mclk);
        end
    endtask
endmodule // target_uart

// file: tb/tb.sv
`timescale 1ns/100ps
module tb;
    import vcom_pkg::*;
    localparam int BC = 8;
    localparam int FR = 10 * BC;
    logic       mclk          = 1'b0;
    logic       reset_n       = 1'b0;
    hs_mode_e   mode_cfg      = HS_RTSCTS;
    logic       port_enable   = 1'b1;
    logic       host_tx_valid = 1'b0;
    logic       host_rx_ready = 1'b0;
    logic [7:0] host_tx_data  = 8'h00;
    logic       target_tx_i, target_rts_i, target_rx_o, target_cts_o, target_cts_oe_n;
    logic       host_tx_ready, host_rx_valid, cts_pin;
    logic [7:0] host_rx_data, b;
    logic [7:0] q[5];
    int         failures = 0;
    int         n_checks = 0;

    always #25 mclk = ~mclk;
    // pull-up on the clear-to-send pin
    assign cts_pin = target_cts_oe_n ? 1'b1 : target_cts_o;

    vcom_flow #(.BIT_CYC(BC), .DEPTH(4)) uut (
        .mclk(mclk), .reset_n(reset_n), .mode_cfg(mode_cfg), .port_enable(port_enable),
        .target_tx_i(target_tx_i), .target_rts_i(target_rts_i), .target_rx_o(target_rx_o),
        .target_cts_o(target_cts_o), .target_cts_oe_n(target_cts_oe_n),
        .host_tx_valid(host_tx_valid), .host_tx_ready(host_tx_ready),
        .host_tx_data(host_tx_data), .host_rx_valid(host_rx_valid),
        .host_rx_ready(host_rx_ready), .host_rx_data(host_rx_data));

    target_uart #(.BIT_CYC(BC)) tgt (.mclk(mclk), .rx_line(target_rx_o), .cts_pin(cts_pin),
        .tx_line(target_tx_i), .rts_out(target_rts_i));

    // =========================================================
    // helpers
    function automatic logic oe_n_exp(hs_mode_e m);
        return (m == HS_DISABLED) || (m == HS_CTS);
    endfunction

    function automatic logic rdy_exp(hs_mode_e m, logic rts, logic en);
        return en && (rts || !m[1]);
    endfunction

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic host_send(input logic [7:0] d);
        int n;
        n = 0;
        host_tx_valid <= 1'b1;
        host_tx_data  <= d;
        @(negedge mclk);
        while (host_tx_ready !== 1'b1 && n < 4 * FR) begin
            @(negedge mclk);
            n++;
        end
        chk("tx_ready_wait", 1'b1, host_tx_ready);
        @(posedge mclk);
        host_tx_valid <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic host_take(input logic [7:0] e);
        int n;
        n = 0;
        @(negedge mclk);
        while (host_rx_valid !== 1'b1 && n < 4 * FR) begin
            @(negedge mclk);
            n++;
        end
        chk("host_rx_valid", 1'b1, host_rx_valid);
        chk("host_rx_data", e, host_rx_data);
        @(posedge mclk);
        host_rx_ready <= 1'b1;
        @(posedge mclk);
        host_rx_ready <= 1'b0;
    endtask

    task automatic final_report();
        if (failures == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // =========================================================
    // scenarios
    initial begin
        void'($urandom(56139));
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        chk("rx_idle", 1'b1, target_rx_o);
        chk("cts_oe_n_rst", 1'b1, target_cts_oe_n);
        chk("rx_valid_rst", 1'b0, host_rx_valid);
        chk("tx_ready_rst", 1'b0, host_tx_ready);
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 4; k++) begin
                @(posedge mclk);
                mode_cfg    <= hs_mode_e'(m);
                tgt.rts_out <= k[0];
                port_enable <= k[1];
                repeat (8) @(negedge mclk);
                chk("cts_oe_n", oe_n_exp(hs_mode_e'(m)), target_cts_oe_n);
                chk("tx_ready", rdy_exp(hs_mode_e'(m), k[0], k[1]), host_tx_ready);
            end
            b = 8'($urandom);
            @(posedge mclk);
            host_send(b);
            repeat (FR + 2 * BC) @(posedge mclk);
            chk("target_rx", b, tgt.rx_q.pop_front());
        end
        b = 8'($urandom);
        host_send(b);
        repeat (2 * BC) @(posedge mclk);
        tgt.rts_out   <= 1'b0;
        host_tx_valid <= 1'b1;
        host_tx_data  <= ~b;
        repeat (FR) @(posedge mclk);
        chk("frame_done", b, tgt.rx_q.pop_front());
        chk("tx_held", 1'b0, host_tx_ready);
        chk("line_held", 1'b1, target_rx_o);
        tgt.rts_out <= 1'b1;
        host_send(~b);
        repeat (FR + 2 * BC) @(posedge mclk);
        chk("tx_resumed", ~b, tgt.rx_q.pop_front());
        mode_cfg    <= HS_RTS;
        tgt.rts_out <= 1'b1;
        port_enable <= 1'b0;
        tgt.send(8'h5a);
        repeat (2 * BC) @(posedge mclk);
        chk("rx_gated", 1'b0, host_rx_valid);
        port_enable <= 1'b1;
        for (int i = 0; i < 5; i++) q[i] = 8'($urandom);
        for (int i = 0; i < 4; i++) tgt.send(q[i]);
        repeat (2 * BC) @(posedge mclk);
        chk("cts_full", 1'b0, cts_pin);
        fork
            tgt.send(q[4]);
        join_none
        repeat (3 * FR) @(posedge mclk);
        for (int i = 0; i < 5; i++) host_take(q[i]);
        repeat (4) @(negedge mclk);
        chk("cts_free", 1'b1, cts_pin);
        final_report();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        final_report();
    end
endmodule // tb
